// File: pee_pkg.sv
package pee_pkg;
  // Operation
  // - device drives data only with select and gate low
  // - write needs select and strobe low, gate high
  // - page address bits 5-12 held for whole page
  // - next strobe within 100 us loads another byte; the host waits in S_PGWAIT with no time limit
  // - chip erase: gate high voltage, data all high

  // ---------------------------------------------------------------
  // geometry and timing
  // ---------------------------------------------------------------
  localparam int ADDR_W      = 13;
  localparam int DATA_W      = 8;
  localparam int PAGE_LSB    = 5;
  localparam int PAGE_BYTES  = 32;
  localparam int CLK_PS      = 25000;
  localparam int STROBE_NS   = 150;   // strobe low width, well above the 20 ns noise floor
  localparam int SETUP_NS    = 100;   // data/address setup
  localparam int HIGH_NS     = 3000;  // least byte load cycle time, 3 us
  localparam int ACCESS_NS   = 250;   // read access
  localparam int ERASE_US    = 10000; // erase strobe width, 10 ms
  localparam int WCYC_US     = 10000; // write cycle time, 10 ms
  localparam int STROBE_CYC  = (STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int SETUP_CYC   = (SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int HIGH_CYC    = (HIGH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int ACCESS_CYC  = (ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS + 1;
  localparam int ERASE_CYC   = (ERASE_US * 1000) / (CLK_PS / 1000) + 1;
  localparam int WCYC_CYC    = (WCYC_US * 1000) / (CLK_PS / 1000) + 1;
  localparam int ESETUP_CYC  = SETUP_CYC * 5;  // select/gate setup before the erase strobe
  localparam int EHOLD_CYC   = HIGH_CYC * 3;   // select/gate hold after the erase strobe
  localparam int CNT_W       = 20;
  localparam logic [DATA_W-1:0] ERASE_DATA = 8'hFF;

  typedef enum logic [1:0] {PEE_READ, PEE_WRITE, PEE_PAGE, PEE_ERASE} pee_op_t;

  typedef struct packed {
    pee_op_t           op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              last;   // last byte of a page load
  } pee_req_t;

  typedef struct packed {
    logic              selectN;
    logic              gateN;
    logic              strobeN;
    logic              gateHv;  // drives gate to the high voltage level
    logic [ADDR_W-1:0] addr;
  } pee_pins_t;
endpackage : pee_pkg

// File: pee_host.sv
`timescale 1ns/100ps
module pee_host #(
  parameter int WRITE_CYCLES = pee_pkg::WCYC_CYC,
  parameter int ERASE_CYCLES = pee_pkg::ERASE_CYC
) (
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  input  wire pee_pkg::pee_req_t         req,
  input  wire logic                      reqValid,
  output logic                           reqReady,
  output logic [pee_pkg::DATA_W-1:0]     rdData,
  output logic                           rdValid,
  output logic                           busy,
  output pee_pkg::pee_pins_t             pins,
  output logic [pee_pkg::DATA_W-1:0]     dataOut,
  output logic                           dataOe,
  input  wire logic [pee_pkg::DATA_W-1:0] dataIn
);
  import pee_pkg::*;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  // each count must fit its CNT_W-bit down-counter (pollCnt for writes, cnt for erase)
  if (WRITE_CYCLES < 2 || WRITE_CYCLES >= (1 << CNT_W))
  begin : g_bad_write
    $error("WRITE_CYCLES out of range");
  end
  if (ERASE_CYCLES < 2 || ERASE_CYCLES >= (1 << CNT_W))
  begin : g_bad_erase
    $error("ERASE_CYCLES out of range");
  end

  typedef enum logic [3:0] {
    S_IDLE, S_RSETUP, S_RSAMPLE, S_WSETUP, S_WLOW, S_WHIGH, S_PGWAIT,
    S_POLL, S_POLLGAP, S_ESETUP, S_ELOW, S_EHOLD, S_DONE
  } pee_state_t;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pee_state_t          state;
  logic [CNT_W-1:0]    cnt;
  logic [CNT_W-1:0]    pollCnt;
  pee_req_t            cur;
  logic [ADDR_W-PAGE_LSB-1:0] pageAddr;
  logic                pageOpen;
  logic [DATA_W-1:0]   sync1;
  logic [DATA_W-1:0]   sync2;

  wire cntDone   = (cnt == '0);
  wire take      = reqValid && reqReady;
  // a page byte must stay inside the open page
  wire pageMatch = !pageOpen || (req.addr[ADDR_W-1:PAGE_LSB] == pageAddr);
  wire bit7Match = (sync2[DATA_W-1] == cur.data[DATA_W-1]);

  // only the idle state and an open page accept new work; a page byte
  // is refused until the least byte load cycle time has run out
  assign reqReady = ((state == S_IDLE) && !pageOpen) ||
                    ((state == S_PGWAIT) && cntDone &&
                     req.op == PEE_PAGE && pageMatch);
  assign busy     = (state != S_IDLE) || pageOpen;

  // ---------------------------------------------------------------
  // pin decode
  // ---------------------------------------------------------------
  wire selLow  = (state != S_IDLE) && (state != S_DONE) && (state != S_PGWAIT);
  wire rdPhase = (state == S_RSETUP) || (state == S_RSAMPLE) || (state == S_POLL);
  wire wrLow   = (state == S_WLOW) || (state == S_ELOW);
  wire wrPhase = (state == S_WSETUP) || (state == S_WLOW) || (state == S_WHIGH) ||
                 (state == S_ESETUP) || (state == S_ELOW) || (state == S_EHOLD);

  // gate stays high whenever the strobe falls, and the data bus is ours only then
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pins    <= '{selectN: 1'b1, gateN: 1'b1, strobeN: 1'b1, gateHv: 1'b0, addr: '0};
      dataOut <= '0;
      dataOe  <= 1'b0;
    end
    else
    begin
      pins.selectN <= !selLow;
      pins.gateN   <= !rdPhase;
      pins.strobeN <= !wrLow;
      pins.gateHv  <= (state == S_ESETUP) || (state == S_ELOW) || (state == S_EHOLD);
      pins.addr    <= cur.addr;
      dataOut      <= (cur.op == PEE_ERASE) ? ERASE_DATA : cur.data;
      dataOe       <= wrPhase;
    end
  end

  // data pins pass two flops before any decision
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= dataIn;
      sync2 <= sync1;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state    <= S_IDLE;
      cnt      <= '0;
      pollCnt  <= '0;
      cur      <= '0;
      pageAddr <= '0;
      pageOpen <= 1'b0;
      rdData   <= '0;
      rdValid  <= 1'b0;
    end
    else
    begin
      rdValid <= 1'b0;
      if (!cntDone)
        cnt <= cnt - 1'b1;
      if (!pollCnt[CNT_W-1] && pollCnt != '0)
        pollCnt <= pollCnt - 1'b1;
      case (state)
        S_IDLE:
        begin
          if (take)
          begin
            cur <= req;
            case (req.op)
              PEE_READ:
              begin
                state <= S_RSETUP;
                cnt   <= CNT_W'(ACCESS_CYC);
              end
              PEE_ERASE:
              begin
                state <= S_ESETUP;
                cnt   <= CNT_W'(ESETUP_CYC);
              end
              default:
              begin
                state <= S_WSETUP;
                cnt   <= CNT_W'(SETUP_CYC);
              end
            endcase
          end
        end
        S_RSETUP:
          if (cntDone) state <= S_RSAMPLE;
        S_RSAMPLE:
        begin
          rdData  <= sync2;
          rdValid <= 1'b1;
          state   <= S_DONE;
        end
        S_WSETUP:
          if (cntDone)
          begin
            state <= S_WLOW;
            cnt   <= CNT_W'(STROBE_CYC);
          end
        S_WLOW:
          if (cntDone)
          begin
            state <= S_WHIGH;
            cnt   <= CNT_W'(SETUP_CYC);
          end
        S_WHIGH:
          if (cntDone)
          begin
            if (cur.op == PEE_PAGE && !cur.last)
            begin
              pageOpen <= 1'b1;
              pageAddr <= cur.addr[ADDR_W-1:PAGE_LSB];
              state    <= S_PGWAIT;
              cnt      <= CNT_W'(HIGH_CYC);
            end
            else
            begin
              pageOpen <= 1'b0;
              pollCnt  <= CNT_W'(WRITE_CYCLES);
              state    <= S_POLL;
              cnt      <= CNT_W'(ACCESS_CYC);
            end
          end
        S_PGWAIT:
          // the next byte is only presented after the least cycle time
          if (take && cntDone)
          begin
            cur   <= req;
            state <= S_WSETUP;
            cnt   <= CNT_W'(SETUP_CYC);
          end
        S_POLL:
          if (cntDone)
          begin
            if (bit7Match || pollCnt == '0)
              state <= S_DONE;
            else
            begin
              state <= S_POLLGAP;
              cnt   <= CNT_W'(SETUP_CYC);
            end
          end
        S_POLLGAP:
          if (cntDone)
          begin
            state <= S_POLL;
            cnt   <= CNT_W'(ACCESS_CYC);
          end
        S_ESETUP:
          if (cntDone)
          begin
            state <= S_ELOW;
            cnt   <= CNT_W'(ERASE_CYCLES);
          end
        S_ELOW:
          if (cntDone)
          begin
            state <= S_EHOLD;
            cnt   <= CNT_W'(EHOLD_CYC);
          end
        S_EHOLD:
          if (cntDone) state <= S_DONE;
        S_DONE:
          state <= S_IDLE;
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule : pee_host

// File: pee_monitor.sv
`timescale 1ns/100ps
module pee_monitor
  import pee_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              sys_rst,
  input wire logic              reqReady,
  input wire logic              rdValid,
  input wire logic              busy,
  input wire pee_pins_t         pins,
  input wire logic [DATA_W-1:0] dataOut,
  input wire logic              dataOe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // pin protocol
  // ----------------------------------------
  a_drive_gate_high: assert property (dataOe |-> pins.gateN && !pins.selectN)
    else $error("host drives bus while gate low");
  a_write_pins: assert property (!pins.strobeN |-> pins.gateN && !pins.selectN && dataOe)
    else $error("strobe low outside write setup");
  a_strobe_width: assert property (
    $fell(pins.strobeN) && !pins.gateHv |-> !pins.strobeN [*7] ##1 pins.strobeN)
    else $error("write strobe width wrong");
  a_addr_data_held: assert property (
    !pins.strobeN && $past(!pins.strobeN) |-> $stable(dataOut) && $stable(pins.addr))
    else $error("address or data moved under strobe");
  a_erase_ones: assert property (pins.gateHv && !pins.strobeN |-> dataOut == ERASE_DATA)
    else $error("erase without all-ones data");
  a_read_pulse: assert property (rdValid |=> !rdValid)
    else $error("read valid longer than one cycle");
  a_idle_ready: assert property (!busy |-> reqReady && pins.strobeN && pins.selectN && !dataOe)
    else $error("idle but not ready");
  a_reset_idle: assert property (disable iff (1'b0) sys_rst |=>
    pins.selectN && pins.strobeN && !pins.gateHv && !dataOe)
    else $error("pins not safe in reset");
  c_strobe: cover property ($fell(pins.strobeN));
  c_read: cover property (rdValid);
  c_erase: cover property (pins.gateHv && !pins.strobeN);
endmodule : pee_monitor

bind pee_host pee_monitor mon_u (.*);

// File: pee_eeprom_model.sv
`timescale 1ns/100ps
module pee_eeprom_model
  import pee_pkg::*;
#(
  parameter int BLC_NS  = 100000,
  parameter int PROG_NS = 1000
) (
  input  wire pee_pins_t         pins,
  input  wire logic [DATA_W-1:0] dataOut,
  input  wire logic              dataOe,
  output logic [DATA_W-1:0]      dataIn
);
  logic [DATA_W-1:0] mem [0:8191];
  logic [ADDR_W-1:0] lastA;
  logic [ADDR_W-1:0] capA;
  logic              last7;
  logic              busyF = 1'b0;
  logic [DATA_W-1:0] noise = 8'hA5;
  realtime           tFall;
  realtime           tLast;
  wire               drv = !pins.selectN && !pins.gateN;
  wire               wrOn = !pins.selectN && !pins.strobeN;
  wire [DATA_W-1:0]  rdv = (busyF && pins.addr == lastA) ?
    {~last7, mem[pins.addr][6:0]} : mem[pins.addr];
  // undriven bus changes every cycle so a stale value never looks valid
  assign dataIn = dataOe ? dataOut : (drv ? rdv : noise);
  initial foreach (mem[i]) mem[i] = 8'hFF;
  initial forever #25 noise = ~noise;
  // a write opens at the later falling select/strobe edge and closes at the earlier rising one
  always @(posedge wrOn)
  begin
    tFall = $realtime;
    capA  = pins.addr;
  end
  always @(negedge wrOn)
    if (pins.gateN && $realtime - tFall > 20)
    begin
      if (pins.gateHv) foreach (mem[i]) mem[i] = 8'hFF;
      else mem[capA] = dataOut;
      lastA = capA;
      last7 = pins.gateHv | dataOut[7];
      busyF = 1'b1;
      tLast = $realtime;
    end
  always #100 if (busyF && $realtime - tLast > BLC_NS + PROG_NS) busyF = 1'b0;
endmodule : pee_eeprom_model

// File: parallel_eeprom_access_bench.sv
`timescale 1ns/100ps
module parallel_eeprom_access_bench;
  import pee_pkg::*;
  logic              core_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              reqValid = 1'b0;
  pee_req_t          req = '0;
  logic              reqReady, rdValid, busy, dataOe;
  logic [DATA_W-1:0] rdData, dataOut, dataIn;
  pee_pins_t         pins;
  int                n_fail = 0;
  int                cmp_count = 0;
  pee_host #(.WRITE_CYCLES(400), .ERASE_CYCLES(50)) dut_u (.core_clk(core_clk),
    .sys_rst(sys_rst), .req(req), .reqValid(reqValid), .reqReady(reqReady),
    .rdData(rdData), .rdValid(rdValid), .busy(busy), .pins(pins), .dataOut(dataOut),
    .dataOe(dataOe), .dataIn(dataIn));
  pee_eeprom_model #(.BLC_NS(5000)) mem_u (.pins(pins), .dataOut(dataOut),
    .dataOe(dataOe), .dataIn(dataIn));
  initial forever #12.5 core_clk = ~core_clk;

  task results;
    $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  task check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task send(input pee_op_t op, input logic [12:0] a, input logic [7:0] d, input logic l);
    int i;
    @(negedge core_clk);
    req = '{op, a, d, l};
    reqValid = 1'b1;
    for (i = 0; i < 4000 && reqReady !== 1'b1; i++) @(negedge core_clk);
    if (reqReady !== 1'b1) check("ready timeout", 1, 0);
    if (reqReady !== 1'b1) results;
    @(negedge core_clk);
    reqValid = 1'b0;
  endtask : send

  task idle(output int c);
    for (c = 0; c < 3000 && busy !== 1'b0; c++) @(negedge core_clk);
    if (busy !== 1'b0) check("busy timeout", 0, 1);
    if (busy !== 1'b0) results;
  endtask : idle

  task rd(input logic [12:0] a, input logic [7:0] exp);
    int i;
    send(PEE_READ, a, 8'h00, 1'b0);
    for (i = 0; i < 100 && rdValid !== 1'b1; i++) @(negedge core_clk);
    if (rdValid !== 1'b1) check("read timeout", 1, 0);
    check("read data", exp, rdData);
    idle(i);
  endtask : rd

  // poll must run past the model's load window plus programming time
  task t_byte;
    int c;
    send(PEE_WRITE, 13'h0123, 8'hA7, 1'b0);
    check("ready while busy", 0, {7'h00, reqReady});
    idle(c);
    // model stays busy 6 us after the strobe; a poll timeout would run past 400 cycles
    check("poll time", 1, {7'h00, c > 240 && c < 360});
    rd(13'h0123, 8'hA7);
  endtask : t_byte

  task t_page;
    int c;
    send(PEE_PAGE, 13'h1FFF, 8'h3C, 1'b0);
    send(PEE_PAGE, 13'h1FE0, 8'hC3, 1'b0);
    send(PEE_PAGE, 13'h1FF1, 8'h5A, 1'b1);
    idle(c);
    check("page poll time", 1, {7'h00, c > 240 && c < 360});
    rd(13'h1FFF, 8'h3C);
    rd(13'h1FE0, 8'hC3);
    rd(13'h1FF1, 8'h5A);
  endtask : t_page

  task t_erase;
    int c;
    send(PEE_ERASE, 13'h0000, 8'h00, 1'b0);
    idle(c);
    rd(13'h0123, 8'hFF);
    rd(13'h1FE0, 8'hFF);
  endtask : t_erase

  initial
  begin
    repeat (16) @(negedge core_clk);
    sys_rst = 1'b0;
    check("reset pins", 8'h07, {5'h00, pins.selectN, pins.gateN, pins.strobeN});
    t_byte;
    t_page;
    t_erase;
    results;
  end
endmodule : parallel_eeprom_access_bench
